// ### design/ebm_pkg.sv
// Package for the expansion bus master port: types, widths, timing constants.
// Assumes one 125 MHz clock; no software-visible registers.
package ebm_pkg;
  localparam int EBM_AW = 32;
  localparam int EBM_DW = 32;
  localparam int EBM_IDW = 8;
  localparam int EBM_NG = 6;
  localparam int EBM_PW = 6;
  localparam logic [13:0] EBM_LEN_LIMIT_RST = 14'd16380;
  localparam logic [13:0] EBM_PEND_LIMIT_RST = 14'd16380;
  localparam logic [4:0] EBM_RETRY_DELAY = 5'd16;
  localparam logic [15:0] EBM_WDOG_RST = 16'hFFFF;
  localparam int EBM_FIFO_W = 40;
  localparam int EBM_FIFO_D = 16;
  // Address windows decoded from the top nibble of the bus address
  localparam logic [3:0] EBM_SPACE_DEBUG = 4'hE;
  localparam logic [3:0] EBM_SPACE_REG = 4'hF;
  localparam logic [3:0] EBM_SPACE_BCAST = 4'hD;
  typedef enum logic [2:0] {
    EBM_OP_LOOPBACK = 3'h0,
    EBM_OP_READ1 = 3'h1,
    EBM_OP_READ2 = 3'h2,
    EBM_OP_WRITE1 = 3'h3,
    EBM_OP_WRITE2 = 3'h4
  } ebm_op_e;
  typedef enum logic [1:0] {
    EBM_DST_BUS = 2'h0,
    EBM_DST_REG = 2'h1,
    EBM_DST_DEBUG = 2'h2,
    EBM_DST_INQ = 2'h3
  } ebm_dst_e;
  typedef enum logic [2:0] {
    EBM_ST_IDLE = 3'b000,
    EBM_ST_ADDR = 3'b001,
    EBM_ST_DATA = 3'b011,
    EBM_ST_WAIT = 3'b010,
    EBM_ST_DONE = 3'b110,
    EBM_ST_BACKOFF = 3'b111,
    EBM_ST_LOCAL = 3'b101
  } ebm_state_e;
endpackage

// ### design/ebm_fifo.sv
// Synchronous FIFO with valid/ready on both sides, flop storage.
// Assumes a single clock and a synchronised active-low reset.
`timescale 1ns/1ps
`default_nettype none
module ebm_fifo #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff, rp_ff, nxt_wp, nxt_rp;
  logic [AW:0] cnt_ff, nxt_cnt;
  logic push, pop;
  always_comb begin
    push = i_in_valid && (cnt_ff != (AW+1)'(DEPTH));
    pop = (cnt_ff != '0) && i_out_ready;
    nxt_wp = push ? wp_ff + 1'b1 : wp_ff;
    nxt_rp = pop ? rp_ff + 1'b1 : rp_ff;
    nxt_cnt = cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
  end
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_ff[wp_ff] <= i_in_data;
    end
  end
  assign o_in_ready = cnt_ff != (AW+1)'(DEPTH);
  assign o_out_valid = cnt_ff != '0;
  assign o_out_data = mem_ff[rp_ff];
endmodule
`default_nettype wire

// ### design/ebm_master.sv
// Expansion bus master port: routes outbound and read-return entries.
// Assumes queues upstream hold entries stable while valid; bus pins synchronous.
`timescale 1ns/1ps
`default_nettype none
module ebm_master
  import ebm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  // Limits programmed elsewhere; loaded in any state whenever their write enable is high
  input wire logic [13:0] i_len_limit,
  input wire logic i_len_limit_we,
  input wire logic [13:0] i_pend_limit,
  input wire logic i_pend_limit_we,
  // Outbound command queue head
  input wire logic i_oq_valid,
  output logic o_oq_pop,
  input wire logic [2:0] i_oq_op,
  input wire logic [EBM_AW-1:0] i_oq_addr,
  input wire logic [3:0] i_oq_size,
  input wire logic [7:0] i_oq_bytes,
  input wire logic [EBM_DW-1:0] i_oq_data0,
  input wire logic [EBM_DW-1:0] i_oq_data1,
  input wire logic [EBM_IDW-1:0] i_oq_mid,
  input wire logic [EBM_IDW-1:0] i_oq_tid,
  input wire logic i_oq_pendable,
  // Read return queue head
  input wire logic i_rq_valid,
  output logic o_rq_pop,
  input wire logic [2:0] i_rq_guest,
  input wire logic [3:0] i_rq_size,
  input wire logic [EBM_PW-1:0] i_rq_ptr,
  output logic [EBM_PW-1:0] o_ram_addr,
  input wire logic [EBM_DW-1:0] i_ram_data,
  // Bus pins
  input wire logic i_bus_own,
  output logic o_bus_req,
  output logic [EBM_AW-1:0] o_ad,
  output logic o_ad_oe_n,
  input wire logic [EBM_DW-1:0] i_ad,
  output logic [2:0] o_type,
  output logic o_slave_ack_n,
  output logic o_slave_ack_oe_n,
  input wire logic i_slave_ack_n,
  input wire logic i_bus_error_n,
  input wire logic i_guest_busy_n,
  input wire logic i_pend_acknowledge_n,
  output logic o_pend_capable_n,
  output logic o_read_return_flag_n,
  output logic [EBM_NG-1:0] o_guest_grant_n,
  input wire logic i_guest_seq_done,
  input wire logic i_pend_return_seen,
  // Guest DMA activity seen by the slave side
  input wire logic i_dma_active,
  input wire logic i_dma_read_addr,
  input wire logic i_dma_write_addr,
  input wire logic i_prefetch_hint_n,
  output logic o_prefetch_ok,
  // Register-space and debug-port side
  output logic o_reg_req,
  output logic o_dbg_req,
  output logic [7:0] o_dbg_addr,
  output logic [EBM_DW-1:0] o_loc_wdata,
  output logic o_loc_we,
  input wire logic i_loc_ack,
  input wire logic [EBM_DW-1:0] i_loc_rdata,
  // Inbound queue via FIFO
  output logic o_inq_valid,
  input wire logic i_inq_ready,
  output logic [EBM_FIFO_W-1:0] o_inq_data,
  // Error reporting
  output logic o_len_err,
  output logic o_pend_err,
  output logic o_wdog_err
);
  logic [1:0] rst_sync_ff;
  logic rstn;
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_sync_ff <= 2'b00;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rstn = rst_sync_ff[1];

  function automatic ebm_dst_e route(input logic [2:0] op, input logic [EBM_AW-1:0] a);
    if (op == EBM_OP_LOOPBACK) begin
      route = EBM_DST_INQ;
    end else if (a[31:28] == EBM_SPACE_DEBUG) begin
      route = EBM_DST_DEBUG;
    end else if (a[31:28] == EBM_SPACE_REG && op != EBM_OP_WRITE2) begin
      route = EBM_DST_REG;
    end else begin
      route = EBM_DST_BUS;
    end
  endfunction

  ebm_state_e st_ff, nxt_st;
  logic is_rr_ff, nxt_is_rr;
  logic beat_ff, nxt_beat;
  logic [13:0] len_cnt_ff, nxt_len_cnt, len_lim_ff, nxt_len_lim;
  logic [13:0] pend_cnt_ff, nxt_pend_cnt, pend_lim_ff, nxt_pend_lim;
  logic pend_out_ff, nxt_pend_out;
  // Pend was offered for the read in flight; the guest answers cycles later
  logic pend_try_ff, nxt_pend_try;
  logic [4:0] bo_cnt_ff, nxt_bo_cnt;
  logic [15:0] wdog_ff, nxt_wdog;
  logic [EBM_DW-1:0] rd0_ff, nxt_rd0;
  logic inq_push;
  logic [EBM_FIFO_W-1:0] inq_word;
  logic fifo_ready;
  logic req_ff, nxt_req;
  logic [EBM_AW-1:0] ad_ff, nxt_ad;
  logic ad_oe_n_ff, nxt_ad_oe_n;
  logic [2:0] type_ff, nxt_type;
  logic ack_n_ff, nxt_ack_n;
  logic pendc_n_ff, nxt_pendc_n;
  logic rrf_n_ff, nxt_rrf_n;
  logic [EBM_NG-1:0] gnt_n_ff, nxt_gnt_n;
  logic oq_pop_ff, nxt_oq_pop, rq_pop_ff, nxt_rq_pop;
  logic reg_req_ff, nxt_reg_req, dbg_req_ff, nxt_dbg_req;
  logic len_err_ff, nxt_len_err, pend_err_ff, nxt_pend_err, wdog_err_ff, nxt_wdog_err;
  logic pf_ok_ff, nxt_pf_ok;
  logic last_beat, two_word, bcast;
  ebm_dst_e dst;

  always_comb begin
    dst = route(i_oq_op, i_oq_addr);
    two_word = is_rr_ff ? (i_rq_size > 4'd4) : (i_oq_op == EBM_OP_READ2 || i_oq_op == EBM_OP_WRITE2);
    // Stream exactly the requested words, never more
    last_beat = !two_word || beat_ff;
    bcast = i_oq_addr[31:28] == EBM_SPACE_BCAST;
    nxt_st = st_ff;
    nxt_is_rr = is_rr_ff;
    nxt_beat = beat_ff;
    nxt_len_cnt = len_cnt_ff;
    nxt_len_lim = i_len_limit_we ? i_len_limit : len_lim_ff;
    nxt_pend_lim = i_pend_limit_we ? i_pend_limit : pend_lim_ff;
    nxt_pend_out = pend_out_ff;
    nxt_pend_try = pend_try_ff;
    nxt_pend_cnt = pend_cnt_ff;
    nxt_bo_cnt = bo_cnt_ff;
    nxt_rd0 = rd0_ff;
    nxt_req = 1'b0;
    nxt_ad = ad_ff;
    nxt_ad_oe_n = 1'b1;
    nxt_type = type_ff;
    nxt_ack_n = 1'b1;
    nxt_pendc_n = 1'b1;
    nxt_rrf_n = 1'b1;
    nxt_gnt_n = '1;
    nxt_oq_pop = 1'b0;
    nxt_rq_pop = 1'b0;
    nxt_reg_req = 1'b0;
    nxt_dbg_req = 1'b0;
    nxt_len_err = 1'b0;
    nxt_pend_err = 1'b0;
    inq_push = 1'b0;
    inq_word = {i_oq_mid, i_oq_tid, i_oq_size, i_oq_bytes, 12'h000};
    // Pended read timer runs until the guest return arrives or the pend limit is reached
    if (pend_out_ff) begin
      if (i_pend_return_seen) begin
        nxt_pend_out = 1'b0;
      end else if (pend_cnt_ff >= pend_lim_ff) begin
        nxt_pend_out = 1'b0;
        nxt_pend_err = 1'b1;
      end else begin
        nxt_pend_cnt = pend_cnt_ff + 14'd1;
      end
    end
    unique case (st_ff)
      EBM_ST_IDLE: begin
        nxt_beat = 1'b0;
        // Read returns outrank outbound work while guest DMA is inactive
        if (i_rq_valid && !i_dma_active) begin
          nxt_is_rr = 1'b1;
          nxt_req = 1'b1;
          nxt_st = EBM_ST_ADDR;
        end else if (i_oq_valid && fifo_ready) begin
          nxt_is_rr = 1'b0;
          if (dst == EBM_DST_BUS) begin
            nxt_req = 1'b1;
            nxt_st = EBM_ST_ADDR;
          end else if (dst == EBM_DST_INQ) begin
            inq_push = 1'b1;
            nxt_oq_pop = 1'b1;
            nxt_st = EBM_ST_DONE;
          end else begin
            nxt_reg_req = dst == EBM_DST_REG;
            nxt_dbg_req = dst == EBM_DST_DEBUG;
            nxt_st = EBM_ST_LOCAL;
          end
        end
      end
      EBM_ST_ADDR: begin
        nxt_req = 1'b1;
        nxt_len_cnt = 14'd0;
        if (i_bus_own) begin
          nxt_req = 1'b0;
          nxt_ad_oe_n = 1'b0;
          if (is_rr_ff) begin
            // Guest addressed by its grant plus the return flag
            nxt_gnt_n[i_rq_guest] = 1'b0;
            nxt_rrf_n = 1'b0;
            nxt_ad = i_ram_data;
            nxt_st = EBM_ST_DATA;
          end else begin
            nxt_ad = i_oq_addr;
            nxt_type = i_oq_op;
            nxt_pend_try = i_oq_pendable && !pend_out_ff
              && (i_oq_op == EBM_OP_READ1 || i_oq_op == EBM_OP_READ2);
            nxt_pendc_n = !nxt_pend_try;
            nxt_st = (i_oq_op == EBM_OP_WRITE1 || i_oq_op == EBM_OP_WRITE2)
              ? EBM_ST_DATA : EBM_ST_WAIT;
          end
        end
      end
      EBM_ST_DATA: begin
        nxt_ad_oe_n = 1'b0;
        nxt_len_cnt = len_cnt_ff + 14'd1;
        if (is_rr_ff) begin
          nxt_gnt_n[i_rq_guest] = last_beat;
          nxt_rrf_n = last_beat;
          nxt_ad = i_ram_data;
          nxt_beat = 1'b1;
          if (last_beat) begin
            nxt_rq_pop = 1'b1;
            nxt_st = EBM_ST_DONE;
          end
        end else begin
          // Data follows the address cycle directly
          nxt_ad = beat_ff ? i_oq_data1 : i_oq_data0;
          nxt_ack_n = !bcast;
          nxt_st = EBM_ST_WAIT;
        end
      end
      EBM_ST_WAIT: begin
        // Master counts wait cycles and drops the entry with a length error at the limit
        nxt_len_cnt = len_cnt_ff + 14'd1;
        if (!i_guest_busy_n) begin
          nxt_bo_cnt = 5'd0;
          nxt_st = EBM_ST_BACKOFF;
        end else if (!i_pend_acknowledge_n && pend_try_ff) begin
          nxt_pend_out = 1'b1;
          nxt_pend_cnt = 14'd0;
          nxt_oq_pop = 1'b1;
          nxt_st = EBM_ST_DONE;
        end else if (!i_slave_ack_n || (bcast && type_ff == EBM_OP_WRITE1)) begin
          if (type_ff == EBM_OP_READ1 || type_ff == EBM_OP_READ2) begin
            nxt_rd0 = i_ad;
            nxt_beat = 1'b1;
            if (last_beat) begin
              inq_push = 1'b1;
              inq_word = {i_oq_mid, i_oq_tid, i_oq_size, i_oq_bytes, 12'h000};
              nxt_oq_pop = 1'b1;
              nxt_st = EBM_ST_DONE;
            end
          end else if (!i_bus_error_n || last_beat) begin
            nxt_oq_pop = 1'b1;
            nxt_st = EBM_ST_DONE;
          end else begin
            // Second word of a double write
            nxt_beat = 1'b1;
            nxt_st = EBM_ST_DATA;
          end
        end else if (len_cnt_ff >= len_lim_ff) begin
          nxt_len_err = 1'b1;
          nxt_oq_pop = 1'b1;
          nxt_st = EBM_ST_DONE;
        end
      end
      EBM_ST_BACKOFF: begin
        // Reattempt after a return, a guest sequence or the fixed delay
        nxt_bo_cnt = bo_cnt_ff + 5'd1;
        if (i_rq_valid || i_guest_seq_done || bo_cnt_ff == EBM_RETRY_DELAY - 5'd1) begin
          nxt_st = EBM_ST_IDLE;
        end
      end
      EBM_ST_LOCAL: begin
        nxt_reg_req = reg_req_ff && !i_loc_ack;
        nxt_dbg_req = dbg_req_ff && !i_loc_ack;
        if (i_loc_ack) begin
          if (i_oq_op == EBM_OP_READ1 || i_oq_op == EBM_OP_READ2) begin
            inq_push = 1'b1;
          end
          nxt_rd0 = i_loc_rdata;
          nxt_oq_pop = 1'b1;
          nxt_st = EBM_ST_DONE;
        end
      end
      EBM_ST_DONE: begin
        nxt_st = EBM_ST_IDLE;
      end
      default: begin
        nxt_st = EBM_ST_IDLE;
      end
    endcase
  end

  // Watchdog over guest tenure only, decremented every cycle until it holds at zero
  always_comb begin
    nxt_wdog = i_dma_active ? (wdog_ff == 16'h0000 ? wdog_ff : wdog_ff - 16'd1) : EBM_WDOG_RST;
    nxt_wdog_err = i_dma_active && wdog_ff == 16'h0001;
    // Hint only counts on a DMA read address cycle; writes ignore it
    if (i_dma_read_addr) begin
      nxt_pf_ok = !i_prefetch_hint_n;
    end else if (i_dma_write_addr) begin
      nxt_pf_ok = pf_ok_ff;
    end else begin
      nxt_pf_ok = pf_ok_ff;
    end
  end

  always_ff @(posedge i_clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= EBM_ST_IDLE;
      is_rr_ff <= 1'b0;
      beat_ff <= 1'b0;
      len_cnt_ff <= 14'd0;
      len_lim_ff <= EBM_LEN_LIMIT_RST;
      pend_cnt_ff <= 14'd0;
      pend_lim_ff <= EBM_PEND_LIMIT_RST;
      pend_out_ff <= 1'b0;
      pend_try_ff <= 1'b0;
      bo_cnt_ff <= 5'd0;
      wdog_ff <= EBM_WDOG_RST;
      rd0_ff <= '0;
      req_ff <= 1'b0;
      ad_ff <= '0;
      ad_oe_n_ff <= 1'b1;
      type_ff <= 3'h0;
      ack_n_ff <= 1'b1;
      pendc_n_ff <= 1'b1;
      rrf_n_ff <= 1'b1;
      gnt_n_ff <= '1;
      oq_pop_ff <= 1'b0;
      rq_pop_ff <= 1'b0;
      reg_req_ff <= 1'b0;
      dbg_req_ff <= 1'b0;
      len_err_ff <= 1'b0;
      pend_err_ff <= 1'b0;
      wdog_err_ff <= 1'b0;
      pf_ok_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      is_rr_ff <= nxt_is_rr;
      beat_ff <= nxt_beat;
      len_cnt_ff <= nxt_len_cnt;
      len_lim_ff <= nxt_len_lim;
      pend_cnt_ff <= nxt_pend_cnt;
      pend_lim_ff <= nxt_pend_lim;
      pend_out_ff <= nxt_pend_out;
      pend_try_ff <= nxt_pend_try;
      bo_cnt_ff <= nxt_bo_cnt;
      wdog_ff <= nxt_wdog;
      rd0_ff <= nxt_rd0;
      req_ff <= nxt_req;
      ad_ff <= nxt_ad;
      ad_oe_n_ff <= nxt_ad_oe_n;
      type_ff <= nxt_type;
      ack_n_ff <= nxt_ack_n;
      pendc_n_ff <= nxt_pendc_n;
      rrf_n_ff <= nxt_rrf_n;
      gnt_n_ff <= nxt_gnt_n;
      oq_pop_ff <= nxt_oq_pop;
      rq_pop_ff <= nxt_rq_pop;
      reg_req_ff <= nxt_reg_req;
      dbg_req_ff <= nxt_dbg_req;
      len_err_ff <= nxt_len_err;
      pend_err_ff <= nxt_pend_err;
      wdog_err_ff <= nxt_wdog_err;
      pf_ok_ff <= nxt_pf_ok;
    end
  end

  // Read entries keep ids, size and byte count in the data path
  ebm_fifo #(.WIDTH(EBM_FIFO_W), .DEPTH(EBM_FIFO_D)) u_inq (
    .i_clk(i_clk),
    .i_rstn(rstn),
    .i_in_valid(inq_push),
    .o_in_ready(fifo_ready),
    .i_in_data(inq_word),
    .o_out_valid(o_inq_valid),
    .i_out_ready(i_inq_ready),
    .o_out_data(o_inq_data)
  );

  assign o_ram_addr = i_rq_ptr + EBM_PW'(beat_ff);
  assign o_oq_pop = oq_pop_ff;
  assign o_rq_pop = rq_pop_ff;
  assign o_bus_req = req_ff;
  assign o_ad = ad_ff;
  assign o_ad_oe_n = ad_oe_n_ff;
  assign o_type = type_ff;
  assign o_slave_ack_n = ack_n_ff;
  assign o_slave_ack_oe_n = ack_n_ff;
  assign o_pend_capable_n = pendc_n_ff;
  assign o_read_return_flag_n = rrf_n_ff;
  assign o_guest_grant_n = gnt_n_ff;
  assign o_prefetch_ok = pf_ok_ff;
  assign o_reg_req = reg_req_ff;
  assign o_dbg_req = dbg_req_ff;
  // Debug port packs the low byte of the last driven AD value and data word 0
  assign o_dbg_addr = ad_ff[7:0];
  assign o_loc_wdata = i_oq_data0;
  assign o_loc_we = i_oq_op == EBM_OP_WRITE1 || i_oq_op == EBM_OP_WRITE2;
  assign o_len_err = len_err_ff;
  assign o_pend_err = pend_err_ff;
  assign o_wdog_err = wdog_err_ff;
endmodule
`default_nettype wire

// ### verif/ebm_guest_model.sv
// Guest device model on the expansion bus: grant, ack, retry, pend or silence.
// Assumes the master opens each cycle by lowering its address enable.
`timescale 1ns/1ps
`default_nettype none
module ebm_guest_model (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_req,
  input wire logic i_oe_n,
  input wire logic [1:0] i_mode,
  output logic o_own,
  output logic o_ack_n,
  output logic o_busy_n,
  output logic o_pack_n,
  output logic [31:0] o_ad
);
  // Modes: 0 ack, 1 silent, 2 retry once then ack, 3 pend
  logic [3:0] cnt_ff;
  logic prev_oe_ff;
  logic busy_done_ff;
  logic resp;
  assign resp = (cnt_ff == 4'h3);
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_own <= 1'h0;
      prev_oe_ff <= 1'h1;
      cnt_ff <= 4'h0;
      busy_done_ff <= 1'h0;
      o_ack_n <= 1'h1;
      o_busy_n <= 1'h1;
      o_pack_n <= 1'h1;
      o_ad <= 32'h0;
    end else begin
      o_own <= i_req;
      prev_oe_ff <= i_oe_n;
      if (prev_oe_ff && !i_oe_n) cnt_ff <= 4'h1;
      else cnt_ff <= resp ? 4'h0 : cnt_ff + 4'(cnt_ff != 4'h0);
      // Silent mode stands for a broadcast slave that keeps off ack
      o_ack_n <= !(resp && (i_mode == 2'h0 || (i_mode == 2'h2 && busy_done_ff)));
      o_busy_n <= !(resp && i_mode == 2'h2 && !busy_done_ff);
      o_pack_n <= !(resp && i_mode == 2'h3);
      busy_done_ff <= (i_mode == 2'h2) && (busy_done_ff || resp);
      // Undriven bus toggles so stale data never looks valid
      o_ad <= (resp && i_mode != 2'h1) ? 32'h5A5A_0001 : ~o_ad;
    end
  end
endmodule
`default_nettype wire

// ### verif/ebm_master_assertions.sv
// Protocol checker for the expansion bus master port.
// Assumes it is bound to ebm_master and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module ebm_master_assertions
  import ebm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_guest_busy_n,
  input wire logic i_dma_read_addr,
  input wire logic o_oq_pop,
  input wire logic o_rq_pop,
  input wire logic o_bus_req,
  input wire logic [EBM_AW-1:0] o_ad,
  input wire logic o_ad_oe_n,
  input wire logic [2:0] o_type,
  input wire logic o_slave_ack_n,
  input wire logic o_slave_ack_oe_n,
  input wire logic o_pend_capable_n,
  input wire logic o_read_return_flag_n,
  input wire logic [EBM_NG-1:0] o_guest_grant_n,
  input wire logic o_prefetch_ok,
  input wire logic o_len_err
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  a_write_data_next: assert property ($fell(o_ad_oe_n) && o_type == EBM_OP_WRITE1 |=> !o_ad_oe_n)
    else $error("write data not driven after address");
  a_bcast_acks: assert property ($fell(o_ad_oe_n) && o_type == EBM_OP_WRITE1
    && o_ad[31:28] == EBM_SPACE_BCAST |=> !o_slave_ack_n && !o_slave_ack_oe_n)
    else $error("broadcast data cycle without own ack");
  a_ack_only_bcast: assert property (!o_slave_ack_n |-> $past(o_ad[31:28]) == EBM_SPACE_BCAST)
    else $error("own ack outside broadcast");
  a_pend_addr_only: assert property (!o_pend_capable_n |-> $fell(o_ad_oe_n)
    && (o_type == EBM_OP_READ1 || o_type == EBM_OP_READ2))
    else $error("pend line outside read address cycle");
  a_return_one_grant: assert property (!o_read_return_flag_n |-> $onehot(~o_guest_grant_n))
    else $error("read return without single grant");
  a_pop_exclusive: assert property (!(o_oq_pop && o_rq_pop))
    else $error("both queues popped");
  a_retry_holds: assert property ($fell(i_guest_busy_n) |=> !o_oq_pop [*8])
    else $error("retried entry popped early");
  a_len_err_pops: assert property (o_len_err |-> ##[0:2] o_oq_pop)
    else $error("timed out entry not popped");
  a_prefetch_cause: assert property ($rose(o_prefetch_ok) |-> $past(i_dma_read_addr)
    || $past(i_dma_read_addr, 2) || $past(i_dma_read_addr, 3))
    else $error("prefetch without read address");
  c_bcast: cover property (!o_slave_ack_n);
  c_return: cover property (!o_read_return_flag_n);
  c_len_err: cover property (o_len_err);
endmodule
bind ebm_master ebm_master_assertions u_chk (.i_clk, .i_rstn, .i_guest_busy_n,
  .i_dma_read_addr, .o_oq_pop, .o_rq_pop, .o_bus_req, .o_ad, .o_ad_oe_n, .o_type,
  .o_slave_ack_n, .o_slave_ack_oe_n, .o_pend_capable_n, .o_read_return_flag_n,
  .o_guest_grant_n, .o_prefetch_ok, .o_len_err);
`default_nettype wire

// ### verif/expansion_bus_master_port_test.sv
// Directed self-checking bench for the expansion bus master port.
// Assumes the guest model answers bus cycles as set through g_mode.
`timescale 1ns/1ps
`default_nettype none
module expansion_bus_master_port_test;
  import ebm_pkg::*;
  logic i_clk = 1'h0;
  logic i_rstn = 1'h0;
  logic [13:0] i_len_limit = 14'h0, i_pend_limit = 14'h0;
  logic i_len_limit_we = 1'h0, i_pend_limit_we = 1'h0, i_oq_valid = 1'h0, i_oq_pendable = 1'h0;
  logic [2:0] i_oq_op = 3'h0, i_rq_guest = 3'h0, o_type;
  logic [3:0] i_oq_size = 4'h1, i_rq_size = 4'h1;
  logic [7:0] i_oq_bytes = 8'h0F, i_oq_mid = 8'h21, i_oq_tid = 8'h42, o_dbg_addr;
  logic [31:0] i_oq_addr = 32'h0, i_oq_data0 = 32'h0, i_oq_data1 = 32'h0, i_ram_data = 32'h0;
  logic [31:0] i_loc_rdata = 32'hFEED_0001, i_ad, o_ad, o_loc_wdata, g_ad, a_addr, a_d0;
  logic i_rq_valid = 1'h0, i_bus_own, i_slave_ack_n, i_bus_error_n = 1'h1, i_guest_busy_n;
  logic i_pend_acknowledge_n, i_guest_seq_done = 1'h0, i_pend_return_seen = 1'h0;
  logic i_dma_active = 1'h0, i_dma_read_addr = 1'h0, i_dma_write_addr = 1'h0;
  logic i_prefetch_hint_n = 1'h1, i_loc_ack = 1'h0, i_inq_ready = 1'h1, g_ack_n;
  logic o_oq_pop, o_rq_pop, o_bus_req, o_ad_oe_n, o_slave_ack_n, o_slave_ack_oe_n, o_loc_we;
  logic o_pend_capable_n, o_read_return_flag_n, o_prefetch_ok, o_reg_req, o_dbg_req;
  logic o_inq_valid, o_len_err, o_pend_err, o_wdog_err, p;
  logic [5:0] i_rq_ptr = 6'h05, o_ram_addr, o_guest_grant_n, gr_seen = 6'h3F;
  logic [39:0] o_inq_data;
  logic [1:0] g_mode = 2'h0;
  logic oe_q = 1'h1, d_take = 1'h0, a_pend = 1'h1, reg_seen = 1'h0, dbg_seen = 1'h0;
  logic pend_seen = 1'h0, len_seen = 1'h0;
  int fails = 0, n_checks = 0, n_addr = 0, n_inq = 0, n0;
  always #4 i_clk = ~i_clk;
  // Shared wires: whoever enables its driver sets the level
  assign i_ad = o_ad_oe_n ? g_ad : o_ad;
  assign i_slave_ack_n = g_ack_n & (o_slave_ack_oe_n | o_slave_ack_n);
  ebm_master u_dut (.i_clk, .i_rstn, .i_len_limit, .i_len_limit_we, .i_pend_limit,
    .i_pend_limit_we, .i_oq_valid, .o_oq_pop, .i_oq_op, .i_oq_addr, .i_oq_size, .i_oq_bytes,
    .i_oq_data0, .i_oq_data1, .i_oq_mid, .i_oq_tid, .i_oq_pendable, .i_rq_valid, .o_rq_pop,
    .i_rq_guest, .i_rq_size, .i_rq_ptr, .o_ram_addr, .i_ram_data, .i_bus_own, .o_bus_req,
    .o_ad, .o_ad_oe_n, .i_ad, .o_type, .o_slave_ack_n, .o_slave_ack_oe_n, .i_slave_ack_n,
    .i_bus_error_n, .i_guest_busy_n, .i_pend_acknowledge_n, .o_pend_capable_n,
    .o_read_return_flag_n, .o_guest_grant_n, .i_guest_seq_done, .i_pend_return_seen,
    .i_dma_active, .i_dma_read_addr, .i_dma_write_addr, .i_prefetch_hint_n, .o_prefetch_ok,
    .o_reg_req, .o_dbg_req, .o_dbg_addr, .o_loc_wdata, .o_loc_we, .i_loc_ack, .i_loc_rdata,
    .o_inq_valid, .i_inq_ready, .o_inq_data, .o_len_err, .o_pend_err, .o_wdog_err);
  ebm_guest_model u_guest (.i_clk, .i_rstn, .i_req(o_bus_req), .i_oe_n(o_ad_oe_n),
    .i_mode(g_mode), .o_own(i_bus_own), .o_ack_n(g_ack_n), .o_busy_n(i_guest_busy_n),
    .o_pack_n(i_pend_acknowledge_n), .o_ad(g_ad));
  always @(posedge i_clk) begin
    oe_q <= o_ad_oe_n;
    d_take <= oe_q && !o_ad_oe_n;
    if (oe_q && !o_ad_oe_n) begin
      a_addr <= o_ad;
      a_pend <= o_pend_capable_n;
      n_addr <= n_addr + 1;
    end
    if (d_take) a_d0 <= o_ad;
    if (o_reg_req) reg_seen <= 1'h1;
    if (o_dbg_req) dbg_seen <= 1'h1;
    if (o_pend_err) pend_seen <= 1'h1;
    if (o_len_err) len_seen <= 1'h1;
    if (!o_read_return_flag_n) gr_seen <= o_guest_grant_n;
    if (o_inq_valid && i_inq_ready) n_inq <= n_inq + 1;
    i_loc_ack <= (o_reg_req || o_dbg_req) && !i_loc_ack;
    i_ram_data <= {26'h2AA_AAAA, o_ram_addr};
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Data words are derived from the address so each cycle is recognisable
  task automatic do_op(input logic [2:0] op, input logic [31:0] a, input logic pd,
                       output logic ok);
    ok = 1'h0;
    i_oq_op <= op;
    i_oq_addr <= a;
    i_oq_data0 <= ~a;
    i_oq_data1 <= {a[15:0], a[31:16]};
    i_oq_pendable <= pd;
    i_oq_valid <= 1'h1;
    for (int k = 0; k < 150 && !ok; k++) begin
      @(negedge i_clk);
      ok = (o_oq_pop === 1'h1);
    end
    @(posedge i_clk);
    i_oq_valid <= 1'h0;
    @(posedge i_clk);
  endtask
  task automatic t_write;
    g_mode <= 2'h0;
    do_op(EBM_OP_WRITE1, 32'h1000_0040, 1'h0, p);
    chk(p, 1'h1);
    chk(a_addr, 32'h1000_0040);
    chk(a_d0, 32'hEFFF_FFBF);
    do_op(EBM_OP_WRITE2, 32'h1000_0080, 1'h0, p);
    chk(p, 1'h1);
    chk(a_d0, 32'h0080_1000);
  endtask
  task automatic t_bcast;
    g_mode <= 2'h1;
    do_op(EBM_OP_WRITE1, 32'hD000_0004, 1'h0, p);
    chk(p, 1'h1);
  endtask
  task automatic t_read;
    g_mode <= 2'h0;
    n0 = n_inq;
    do_op(EBM_OP_READ1, 32'h2000_0010, 1'h0, p);
    chk(p, 1'h1);
    chk(a_pend, 1'h1);
    repeat (4) @(posedge i_clk);
    chk(n_inq - n0, 32'h1);
  endtask
  task automatic t_retry;
    g_mode <= 2'h2;
    n0 = n_addr;
    do_op(EBM_OP_WRITE1, 32'h2000_0014, 1'h0, p);
    chk(p, 1'h1);
    chk(n_addr - n0, 32'h2);
  endtask
  task automatic t_local;
    g_mode <= 2'h0;
    do_op(EBM_OP_WRITE1, 32'hF000_0008, 1'h0, p);
    chk(reg_seen & p, 1'h1);
    do_op(EBM_OP_READ1, 32'hE000_000C, 1'h0, p);
    chk(dbg_seen & p, 1'h1);
    do_op(EBM_OP_WRITE2, 32'hE000_0010, 1'h0, p);
    chk(p, 1'h1);
  endtask
  task automatic t_return;
    p = 1'h0;
    i_rq_guest <= 3'h3;
    i_rq_valid <= 1'h1;
    for (int k = 0; k < 100 && !p; k++) begin
      @(negedge i_clk);
      p = (o_rq_pop === 1'h1);
    end
    @(posedge i_clk);
    i_rq_valid <= 1'h0;
    chk(p, 1'h1);
    chk(gr_seen, 6'h37);
  endtask
  task automatic t_pend;
    i_pend_limit <= 14'h0028;
    i_pend_limit_we <= 1'h1;
    @(posedge i_clk);
    i_pend_limit_we <= 1'h0;
    g_mode <= 2'h3;
    do_op(EBM_OP_READ1, 32'h2000_0020, 1'h1, p);
    chk(a_pend, 1'h0);
    repeat (20) @(posedge i_clk);
    chk(pend_seen, 1'h0);
    repeat (60) @(posedge i_clk);
    chk(pend_seen, 1'h1);
  endtask
  task automatic t_len;
    i_len_limit <= 14'h001E;
    i_len_limit_we <= 1'h1;
    @(posedge i_clk);
    i_len_limit_we <= 1'h0;
    g_mode <= 2'h1;
    do_op(EBM_OP_WRITE1, 32'h2000_0030, 1'h0, p);
    chk(len_seen & p, 1'h1);
  endtask
  task automatic t_prefetch;
    i_dma_active <= 1'h1;
    i_dma_write_addr <= 1'h1;
    i_prefetch_hint_n <= 1'h0;
    @(posedge i_clk);
    i_dma_write_addr <= 1'h0;
    repeat (3) @(posedge i_clk);
    chk(o_prefetch_ok, 1'h0);
    i_dma_read_addr <= 1'h1;
    @(posedge i_clk);
    i_dma_read_addr <= 1'h0;
    i_prefetch_hint_n <= 1'h1;
    repeat (3) @(posedge i_clk);
    chk(o_prefetch_ok, 1'h1);
    i_dma_active <= 1'h0;
  endtask
  // Inbound side stalls: sixteen loop-backs fit, the next is refused
  task automatic t_fifo;
    i_inq_ready <= 1'h0;
    n0 = n_inq;
    for (int k = 0; k < 17; k++) begin
      do_op(EBM_OP_LOOPBACK, 32'h3000_0000, 1'h0, p);
      chk(p, k < 16);
    end
    i_inq_ready <= 1'h1;
    repeat (40) @(posedge i_clk);
    chk(n_inq - n0, 32'h10);
  endtask
  initial begin
    repeat (20) @(posedge i_clk);
    i_rstn <= 1'h1;
    repeat (3) @(posedge i_clk);
    t_write;
    t_bcast;
    t_read;
    t_retry;
    t_local;
    t_return;
    t_pend;
    t_len;
    t_prefetch;
    t_fifo;
    report_and_stop;
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    fails++;
    report_and_stop;
  end
endmodule
`default_nettype wire
